// [dv/eeprom_loader_model.sv]
// partner model: serial store that streams the station address bytes at power-on
`timescale 1ns/1ps
`default_nettype none
module eeprom_loader_model
    import addr_filter_pkg::*;
#(
    parameter logic [47:0] IMAGE = 48'h0,  // byte k of the store sits at bits 8k-1:8k-8
    parameter int          GAP   = 0       // idle cycles between bytes, models a slow store
)(
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire logic     go,
    input  wire logic     programmed,  // store holds an image
    output var  ee_byte_t ee_byte,
    output var  logic     ee_programmed,
    output var  logic     ee_done
);
    logic [7:0] pos_r;   // next store address, zero while idle
    int         wait_r;  // idle cycles left before the next byte
    assign ee_programmed = programmed;  // blank or programmed store
    // one byte per slot, then a done pulse
    always_ff @(posedge aclk) begin
        ee_done       <= 1'b0;
        ee_byte.valid <= 1'b0;
        ee_byte.data  <= ~ee_byte.data;  // stale data keeps moving so it is never mistaken
        if (!aresetn) begin
            pos_r   <= 8'h00;
            wait_r  <= 0;
            ee_byte <= '0;
        end else if (go && pos_r == 8'h00) begin
            pos_r <= EE_FIRST_ADDR_BYTE;
        end else if (pos_r != 8'h00) begin
            if (wait_r != 0) begin
                wait_r <= wait_r - 1;
            end else if (pos_r > EE_LAST_ADDR_BYTE) begin
                ee_done <= 1'b1;
                pos_r   <= 8'h00;
            end else begin
                ee_byte <= '{valid: 1'b1, addr: pos_r, data: IMAGE[8*(pos_r-8'h01) +: 8]};
                pos_r   <= pos_r + 8'h01;
                wait_r  <= GAP;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/station_address_hash_filter_props.sv]
// checker: read answers, verdict timing and read-back properties of the filter
`timescale 1ns/1ps
`default_nettype none
module station_address_hash_filter_props
    import addr_filter_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire rx_byte_t    rx_byte,
    input wire verdict_t    verdict
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [2:0]  cnt_r;  // bytes seen of the current destination
    logic        six_r;  // sixth byte taken at the last edge
    logic        grp_r;  // group bit of the first byte
    logic [31:0] ar_r;   // address of the pending read
    // byte counter restarts on the first-byte mark
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 3'h0;
            six_r <= 1'b0;
        end else begin
            six_r <= rx_byte.valid && !rx_byte.first && cnt_r == 3'h5;
            if (rx_byte.valid) cnt_r <= rx_byte.first ? 3'h1 : cnt_r + 3'h1;
        end
    end
    // remember what later answers must agree with
    always_ff @(posedge aclk) begin
        if (rx_byte.valid && rx_byte.first) grp_r <= rx_byte.data[0];
        if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
    end
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_verdict_time: assert property (verdict.valid == six_r)
        else $error("verdict not one cycle after sixth byte");
    a_verdict_pulse: assert property (verdict.valid |=> !verdict.valid)
        else $error("verdict valid longer than one cycle");
    a_group_flag: assert property (verdict.valid |-> verdict.group == grp_r)
        else $error("group flag not taken from first byte");
    a_unicast_accept: assert property (verdict.valid && !verdict.group |-> verdict.accept == verdict.station_match)
        else $error("unicast accept differs from station match");
    a_high_reserved: assert property (s_axi_rvalid && ar_r == 32'h8 |-> s_axi_rdata[31:16] == 16'h0)
        else $error("reserved high bits read nonzero");
    a_unmapped_err: assert property (s_axi_rvalid && !(ar_r inside {32'h8, 32'hc, 32'h10, 32'h14, 32'h24})
        |-> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule
bind station_address_hash_filter station_address_hash_filter_props i_props (.*);
`default_nettype wire

// [dv/tb_station_address_hash_filter.sv]
// testbench: register access, power-on load and filter verdict scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_station_address_hash_filter
    import addr_filter_pkg::*;
;
    localparam logic [31:0] A_HI = {26'h0, IDX_STATION_ADDRESS_HIGH, 2'b00};
    localparam logic [31:0] A_LO = {26'h0, IDX_STATION_ADDRESS_LOW, 2'b00};
    localparam logic [31:0] A_HU = {26'h0, IDX_GROUP_HASH_UPPER, 2'b00};
    localparam logic [31:0] A_HL = {26'h0, IDX_GROUP_HASH_LOWER, 2'b00};
    localparam logic [31:0] A_CT = {26'h0, IDX_FILTER_CONTROL, 2'b00};
    logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, prog = 1'b0;  // clock, reset, load start, image present
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;      // bus payloads
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;     // write handshakes
    logic        arvalid = 1'b0, rready = 1'b0;                    // read handshakes
    logic        awready, wready, bvalid, arready, rvalid, ee_prog, ee_done;
    logic [1:0]  bresp, rresp;
    ee_byte_t    ee;
    rx_byte_t    rx = '0;
    verdict_t    verdict, v;
    int          num_errors = 0, checks = 0;
    station_address_hash_filter i_station_address_hash_filter (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ee_byte(ee), .ee_programmed(ee_prog), .ee_done(ee_done),
        .rx_byte(rx), .verdict(verdict));
    // store image 12-34-56-78-9a-bc at addresses 1..6, slow store
    eeprom_loader_model #(.IMAGE(48'hbc9a78563412), .GAP(2)) i_eeprom_loader_model (.aclk(aclk),
        .aresetn(aresetn), .go(go), .programmed(prog), .ee_byte(ee), .ee_programmed(ee_prog),
        .ee_done(ee_done));
    always #4 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // master write: offers both channels, releases each once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        // no cycle count assumed: only the watchdog ends this wait
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    // six destination bytes back to back, verdict sampled one edge after the sixth
    task automatic send(input logic [47:0] da);
        for (int i = 0; i < 6; i++) begin
            @(posedge aclk);
            rx <= '{valid: 1'b1, first: (i == 0), data: da[47-8*i -: 8]};
        end
        @(posedge aclk);
        rx.valid <= 1'b0;
        @(posedge aclk);
        v = verdict;
    endtask
    // reflected crc over the destination, low bit of each byte first
    function automatic logic [5:0] hidx(input logic [47:0] da);
        logic [31:0] c;
        c = '1;
        for (int i = 0; i < 48; i++) c = (c[0] ^ da[40-8*(i/8)+i%8]) ? (c >> 1) ^ CRC_POLY_REFLECTED : c >> 1;
        return c[31:26];
    endfunction
    task automatic t_reset_values();
        logic [31:0] d;
        logic [1:0]  r;
        rd(A_HI, d, r);
        chk("high reset", 32'h0000ffff, d);
        rd(A_LO, d, r);
        chk("low reset", 32'h0fffffff, d);
        rd(A_HU, d, r);
        chk("upper reset", 32'h0, d);
        rd(A_HL, d, r);
        chk("lower reset", 32'h0, d);
        wr(A_LO, 32'h11223344, r);
        chk("early resp", 32'(RESP_SLVERR), 32'(r));
        rd(A_LO, d, r);
        chk("early low", 32'h0fffffff, d);
        $display("test reset and early write done");
    endtask
    // blank store: bytes stream past but must be ignored, then a mid-run reset
    task automatic t_blank_load();
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk) go <= 1'b1;
        @(posedge aclk) go <= 1'b0;
        repeat (40) begin
            rd(A_CT, d, r);
            if (d[CTRL_INIT_DONE_BIT] === 1'b1) break;
        end
        chk("blank flags", 32'h100, d & 32'h300);
        rd(A_LO, d, r);
        chk("blank low", 32'h0fffffff, d);
        rd(A_HI, d, r);
        chk("blank high", 32'h0000ffff, d);
        @(posedge aclk) aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        {aresetn, prog} <= 2'b11;
        @(posedge aclk);
        $display("test blank store done");
    endtask
    task automatic t_power_on_load();
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk) go <= 1'b1;
        @(posedge aclk) go <= 1'b0;
        repeat (40) begin
            rd(A_CT, d, r);
            if (d[CTRL_INIT_DONE_BIT] === 1'b1) break;
        end
        chk("load flags", 32'h300, d & 32'h300);
        rd(A_LO, d, r);
        chk("loaded low", 32'h78563412, d);
        rd(A_HI, d, r);
        chk("loaded high", 32'h0000bc9a, d);
        $display("test power-on load done");
    endtask
    task automatic t_host_write();
        logic [31:0] d;
        logic [1:0]  r;
        wr(A_HI, 32'hffffffff, r);
        chk("host resp", 32'(RESP_OKAY), 32'(r));
        rd(A_HI, d, r);
        chk("high reserved", 32'h0000ffff, d);
        wr(A_HI, 32'h0000bc9a, r);
        rd(32'h40, d, r);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        $display("test host write done");
    endtask
    task automatic t_filter();
        logic [31:0] d;
        logic [1:0]  r;
        logic [5:0]  i;
        send(48'h123456789abc);
        chk("station verdict", 32'hd, 32'(v));
        send(48'hbc9a78563412);
        chk("reversed verdict", 32'h8, 32'(v));
        i = hidx(48'h01005e000001);
        d = 32'h1 << i[4:0];
        wr(A_HU, i[5] ? d : 32'h0, r);
        wr(A_HL, i[5] ? 32'h0 : d, r);
        send(48'h01005e000001);
        chk("hash hit", 32'hb, 32'(v));
        wr(A_HU, i[5] ? ~d : '1, r);
        wr(A_HL, i[5] ? '1 : ~d, r);
        send(48'h01005e000001);
        chk("hash miss", 32'ha, 32'(v));
        wr(A_CT, 32'h1, r);
        send(48'h01005e000001);
        chk("pass all", 32'hb, 32'(v));
        $display("test filter verdicts done");
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_values();
        t_blank_load();
        t_power_on_load();
        t_host_write();
        t_filter();
        complete_run();
    end
    // the whole sequence needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire

// [logic/addr_filter_pkg.sv]
// package: register map, reset values, load layout and filter structs for the address filter
package addr_filter_pkg;
    // printed offsets are not all multiples of four, so they are indices
    localparam logic [3:0]  IDX_STATION_ADDRESS_HIGH = 4'h2;
    localparam logic [3:0]  IDX_STATION_ADDRESS_LOW  = 4'h3;
    localparam logic [3:0]  IDX_GROUP_HASH_UPPER     = 4'h4;
    localparam logic [3:0]  IDX_GROUP_HASH_LOWER     = 4'h5;
    localparam logic [3:0]  IDX_FILTER_CONTROL       = 4'h9;  // pass-all-multicast + load status
    // reset values
    localparam logic [31:0] RST_STATION_ADDRESS_HIGH = 32'h0000ffff;
    localparam logic [31:0] RST_STATION_ADDRESS_LOW  = 32'h0fffffff;
    localparam logic [31:0] RST_GROUP_HASH           = 32'h00000000;
    // field positions
    localparam int          ADDR_HIGH_USED_BITS      = 16;
    localparam int          CTRL_PASS_ALL_BIT        = 0;
    localparam int          CTRL_INIT_DONE_BIT       = 8;
    localparam int          CTRL_LOADED_BIT          = 9;
    // serial store byte addresses of the station address
    localparam logic [7:0]  EE_FIRST_ADDR_BYTE       = 8'h01;
    localparam logic [7:0]  EE_LAST_ADDR_BYTE        = 8'h06;
    // axi responses
    localparam logic [1:0]  RESP_OKAY                = 2'b00;
    localparam logic [1:0]  RESP_SLVERR              = 2'b10;
    localparam logic [31:0] CRC_POLY_REFLECTED       = 32'hedb88320;

    // one byte from the power-on loader
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } ee_byte_t;

    // one received destination byte
    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } rx_byte_t;

    // filter verdict for the frame
    typedef struct packed {
        logic valid;
        logic station_match;
        logic group;
        logic accept;
    } verdict_t;
endpackage

// [logic/station_address_hash_filter.sv]
// station address, group hash table and multicast accept logic behind an axi4-lite slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - high register holds address 47:32, resets 0000ffff
// - low register holds address 31:0
// - load address from programmed store at power-on
// - store bytes 1..4 fill low register
// - store bytes 5,6 fill high register
// - first wire byte matches low bits 7:0
// - host writes address after initialisation only
// - two 32-bit words form 64-entry hash
// - index msb picks word, rest picks bit
// - hash bit one accepts, zero rejects
// - pass-all-multicast accepts every group frame
module station_address_hash_filter
    import addr_filter_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // power-on loader (same clock)
    input  wire ee_byte_t    ee_byte,
    input  wire logic        ee_programmed,
    input  wire logic        ee_done,
    // received destination bytes
    input  wire rx_byte_t    rx_byte,
    output var  verdict_t    verdict
);
    // registers
    logic [15:0] addr_high_r;      // address 47:32
    logic [31:0] addr_low_r;       // address 31:0
    logic [31:0] hash_upper_r;     // hash entries 63:32
    logic [31:0] hash_lower_r;     // hash entries 31:0
    logic        pass_all_r;       // pass_all_multicast
    logic        init_done_r;      // power-on load finished
    logic        loaded_r;         // address came from the store

    // axi handshake state
    logic        aw_held_r;        // write address captured
    logic [31:0] aw_addr_r;
    logic        w_held_r;         // write data captured
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_fire;          // both halves present, no response pending
    logic [3:0]  wr_idx;
    logic        wr_hit;
    logic [3:0]  rd_idx;

    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_idx  = aw_addr_r[5:2];
    assign rd_idx  = s_axi_araddr[5:2];
    // upper address bits must be zero for a hit
    assign wr_hit  = (aw_addr_r[31:6] == 26'h0) && (aw_addr_r[1:0] == 2'b00);

    // byte-merge helper honouring wstrb
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // write address channel: accept one and hold until the response is issued
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 32'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    // write data channel, independent of address order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // ready is registered: high while the channel slot is empty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !(aw_held_r || (s_axi_awvalid && s_axi_awready)) || wr_fire;
            s_axi_wready  <= !(w_held_r || (s_axi_wvalid && s_axi_wready)) || wr_fire;
        end
    end

    // write response; unmapped or early address writes answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (!wr_hit) begin
                s_axi_bresp <= RESP_SLVERR;
            end else begin
                case (wr_idx)
                    IDX_STATION_ADDRESS_HIGH,
                    IDX_STATION_ADDRESS_LOW:
                        s_axi_bresp <= init_done_r ? RESP_OKAY : RESP_SLVERR;
                    IDX_GROUP_HASH_UPPER,
                    IDX_GROUP_HASH_LOWER,
                    IDX_FILTER_CONTROL:
                        s_axi_bresp <= RESP_OKAY;
                    default:
                        s_axi_bresp <= RESP_SLVERR;
                endcase
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // station address: power-on load first, host writes after initialisation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_high_r <= RST_STATION_ADDRESS_HIGH[15:0];
            addr_low_r  <= RST_STATION_ADDRESS_LOW;
        end else if (!init_done_r) begin
            // load only from a programmed store
            if (ee_byte.valid && ee_programmed) begin
                case (ee_byte.addr)
                    8'h01: addr_low_r[7:0]    <= ee_byte.data;
                    8'h02: addr_low_r[15:8]   <= ee_byte.data;
                    8'h03: addr_low_r[23:16]  <= ee_byte.data;
                    8'h04: addr_low_r[31:24]  <= ee_byte.data;
                    8'h05: addr_high_r[7:0]   <= ee_byte.data;
                    8'h06: addr_high_r[15:8]  <= ee_byte.data;
                    default: ;                                 // other store bytes are not ours
                endcase
            end
        end else if (wr_fire && wr_hit) begin
            if (wr_idx == IDX_STATION_ADDRESS_HIGH) begin
                // reserved upper half is dropped
                addr_high_r <= 16'(merge({16'h0, addr_high_r}, w_data_r, w_strb_r));
            end
            if (wr_idx == IDX_STATION_ADDRESS_LOW) begin
                addr_low_r <= merge(addr_low_r, w_data_r, w_strb_r);
            end
        end
    end

    // initialisation tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_done_r <= 1'b0;
            loaded_r    <= 1'b0;
        end else if (!init_done_r && ee_done) begin
            init_done_r <= 1'b1;
            loaded_r    <= ee_programmed;
        end
    end

    // hash table and control, writable at any time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hash_upper_r <= RST_GROUP_HASH;
            hash_lower_r <= RST_GROUP_HASH;
            pass_all_r   <= 1'b0;
        end else if (wr_fire && wr_hit) begin
            case (wr_idx)
                IDX_GROUP_HASH_UPPER: hash_upper_r <= merge(hash_upper_r, w_data_r, w_strb_r);
                IDX_GROUP_HASH_LOWER: hash_lower_r <= merge(hash_lower_r, w_data_r, w_strb_r);
                IDX_FILTER_CONTROL:   if (w_strb_r[0]) pass_all_r <= w_data_r[CTRL_PASS_ALL_BIT];
                default: ;
            endcase
        end
    end

    // read channel: one read at a time, data one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            if ((s_axi_araddr[31:6] != 26'h0) || (s_axi_araddr[1:0] != 2'b00)) begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= RESP_SLVERR;
            end else begin
                case (rd_idx)
                    IDX_STATION_ADDRESS_HIGH: s_axi_rdata <= {16'h0, addr_high_r};
                    IDX_STATION_ADDRESS_LOW:  s_axi_rdata <= addr_low_r;
                    IDX_GROUP_HASH_UPPER:     s_axi_rdata <= hash_upper_r;
                    IDX_GROUP_HASH_LOWER:     s_axi_rdata <= hash_lower_r;
                    IDX_FILTER_CONTROL:       s_axi_rdata <= {22'h0, loaded_r, init_done_r, 7'h0, pass_all_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // receive side: six destination bytes, compared and hashed one per beat
    logic [2:0]  rx_cnt_r;     // bytes seen of this destination
    logic [31:0] crc_r;        // running crc over destination
    logic        match_r;      // all bytes so far equal station address
    logic        group_r;      // group bit of first byte
    logic [7:0]  want_byte;
    logic [2:0]  pos;
    logic [31:0] crc_seed;
    logic [31:0] crc_next;
    logic [5:0]  hash_idx;
    logic        hash_bit;

    assign pos = rx_byte.first ? 3'd0 : rx_cnt_r;

    // byte n on the wire is byte n of {high,low} counting from low bit 7:0
    always_comb begin
        case (pos)
            3'd0:    want_byte = addr_low_r[7:0];
            3'd1:    want_byte = addr_low_r[15:8];
            3'd2:    want_byte = addr_low_r[23:16];
            3'd3:    want_byte = addr_low_r[31:24];
            3'd4:    want_byte = addr_high_r[7:0];
            default: want_byte = addr_high_r[15:8];
        endcase
    end

    // reflected crc-32, lsb first as on the wire
    always_comb begin
        crc_seed = rx_byte.first ? 32'hffffffff : crc_r;
        crc_next = crc_seed;
        for (int b = 0; b < 8; b++) begin
            crc_next = (crc_next[0] ^ rx_byte.data[b]) ?
                       ((crc_next >> 1) ^ CRC_POLY_REFLECTED) : (crc_next >> 1);
        end
    end

    // top six bits of the final crc pick the entry; msb picks the word
    assign hash_idx = crc_next[31:26];
    assign hash_bit = hash_idx[5] ? hash_upper_r[hash_idx[4:0]]
                                  : hash_lower_r[hash_idx[4:0]];

    // track the destination and emit a verdict after the sixth byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_cnt_r <= 3'd0;
            crc_r    <= 32'hffffffff;
            match_r  <= 1'b0;
            group_r  <= 1'b0;
            verdict  <= '0;
        end else begin
            verdict.valid <= 1'b0;
            if (rx_byte.valid && (rx_byte.first || rx_cnt_r != 3'd0)) begin
                crc_r    <= crc_next;
                match_r  <= (rx_byte.first || match_r) && (rx_byte.data == want_byte);
                if (rx_byte.first) begin
                    group_r <= rx_byte.data[0];
                end
                rx_cnt_r <= (pos == 3'd5) ? 3'd0 : pos + 3'd1;
                if (pos == 3'd5) begin
                    verdict.valid         <= 1'b1;
                    verdict.station_match <= match_r && (rx_byte.data == want_byte);
                    verdict.group         <= group_r;
                    // hash applies to group destinations only
                    verdict.accept        <= group_r ? (pass_all_r || hash_bit)
                                                     : (match_r && (rx_byte.data == want_byte));
                end
            end
        end
    end
endmodule
`default_nettype wire
